/* logic/nv_access_pkg.sv */
// constants and types shared by the eeprom access controller
package nv_access_pkg;

  // register offsets in the byte-wide i/o space
  localparam logic [5:0] OFS_CONTROL   = 6'h1f;
  localparam logic [5:0] OFS_DATA      = 6'h20;
  localparam logic [5:0] OFS_ADDR_LO   = 6'h21;
  localparam logic [5:0] OFS_ADDR_HI   = 6'h22;

  // control register bit positions
  localparam int BIT_READ_STROBE       = 0;
  localparam int BIT_WRITE_STROBE      = 1;
  localparam int BIT_MASTER_WE         = 2;
  localparam int BIT_READY_IRQ_EN      = 3;
  localparam int BIT_MODE_LO           = 4;
  localparam int BIT_MODE_HI           = 5;

  // address layout
  localparam int ADDR_W                = 10;
  localparam int ADDR_HI_W             = ADDR_W - 8;

  // reset values
  localparam logic [7:0] RST_DATA      = 8'h00;
  localparam logic [1:0] RST_MODE      = 2'h0;
  localparam logic       RST_IRQ_EN    = 1'b0;

  // programming mode encodings
  localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
  localparam logic [1:0] MODE_ERASE_ONLY  = 2'h1;
  localparam logic [1:0] MODE_WRITE_ONLY  = 2'h2;
  localparam logic [1:0] MODE_RESERVED    = 2'h3;

  // timing counts in clock cycles
  localparam logic [2:0] MWE_WINDOW    = 3'h4;
  localparam logic [2:0] WRITE_STALL   = 3'h2;
  localparam logic [2:0] READ_STALL    = 3'h4;
  localparam int         PROG_PLL_CYCLES = 27200;
  localparam int         PROG_CNT_W    = 16;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_WRITE
  } prog_state_e;

endpackage

/* logic/eeprom_access_controller.sv */
// register-driven eeprom access controller: strobed reads, timed programming
`timescale 1ns/10ps

// Functional notes
// - Address bits 15:10 and control bits 7:6 read back as zero.
// - The eeprom is addressed linearly by a 10-bit address, 0 to 1023.
// - Data register supplies the write byte; after a read it holds the fetched byte.
// - Mode 00 erase plus write, 01 erase only, 10 write only, 11 reserved.
// - Writes to the mode field are ignored while the write strobe is set.
// - A plain reset clears mode to 00 unless programming is still in progress; por always clears it.
// - Ready interrupt enabled by its enable bit only while global flag set.
// - Enabled ready interrupt is a level held while write strobe is clear.
// - Write strobe set within four cycles of master enable programs the address.
// - Write strobe set with master enable zero is ignored.
// - Hardware clears master write enable four cycles after software sets it.
// - Write strobe stays set while programming and clears when time elapses.
// - Setting the write strobe stalls the cpu for two cycles.
// - Read strobe fetches the byte at once and stalls the cpu four cycles.
// - While programming, read strobes are refused and address writes blocked.
// - Programming is timed as 27200 clock cycles per write step.
// - Brown-out during programming leaves the operation result invalid.
module eeprom_access_controller
  import nv_access_pkg::*;
#(
  parameter int ERASE_CYCLES = PROG_PLL_CYCLES,
  parameter int WRITE_CYCLES = PROG_PLL_CYCLES
) (
  // clock and resets
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             por,
  input  wire logic             brownout_detector,
  // cpu i/o space
  input  wire logic [5:0]       io_addr,
  input  wire logic             io_we,
  input  wire logic [7:0]       io_wdata,
  output logic      [7:0]       io_rdata,
  input  wire logic             global_irq_flag,
  output logic                  cpu_stall,
  output logic                  ready_irq,
  // eeprom array
  output logic      [ADDR_W-1:0] arr_addr,
  output logic      [7:0]       arr_wdata,
  output logic                  arr_read,
  output logic                  arr_erase,
  output logic                  arr_write,
  input  wire logic [7:0]       arr_rdata,
  output logic                  result_invalid
);

  localparam logic [PROG_CNT_W-1:0] ERASE_LOAD = PROG_CNT_W'(ERASE_CYCLES - 1);
  localparam logic [PROG_CNT_W-1:0] WRITE_LOAD = PROG_CNT_W'(WRITE_CYCLES - 1);

  logic [ADDR_W-1:0]     addr_q;
  logic [7:0]            data_q;
  logic [1:0]            mode_q;
  logic                  irq_en_q;
  logic                  mwe_q;
  logic [2:0]            mwe_cnt_q;
  logic                  rd_pend_q;
  logic [2:0]            stall_q;
  prog_state_e           state_q;
  logic [PROG_CNT_W-1:0] prog_cnt_q;
  logic [ADDR_W-1:0]     op_addr_q;
  logic [7:0]            op_data_q;
  logic                  invalid_q;
  logic                  bod_meta_q;
  logic                  bod_q;

  logic busy;
  logic ctrl_wr;
  logic strobe_req;
  logic start_wr;
  logic read_req;

  assign busy       = (state_q != ST_IDLE);
  assign ctrl_wr    = io_we && (io_addr == OFS_CONTROL);
  assign strobe_req = ctrl_wr && io_wdata[BIT_WRITE_STROBE];
  assign start_wr   = strobe_req && mwe_q && !busy;
  assign read_req   = ctrl_wr && io_wdata[BIT_READ_STROBE] && !busy;

  // brown-out comes from analog logic, so it is synchronised first
  always_ff @(posedge clk) begin
    bod_meta_q <= brownout_detector;
    bod_q      <= bod_meta_q;
  end

  // address register: only the low ten bits exist
  always_ff @(posedge clk) begin
    if (io_we && !busy && (io_addr == OFS_ADDR_LO)) begin
      addr_q[7:0] <= io_wdata;
    end
    if (io_we && !busy && (io_addr == OFS_ADDR_HI)) begin
      addr_q[ADDR_W-1:8] <= io_wdata[ADDR_HI_W-1:0];
    end
  end

  // data register: cpu writes, array read result lands here
  always_ff @(posedge clk) begin
    if (reset || por) begin
      data_q <= RST_DATA;
    end else if (rd_pend_q) begin
      data_q <= arr_rdata;
    end else if (io_we && (io_addr == OFS_DATA)) begin
      data_q <= io_wdata;
    end
  end

  // ready interrupt enable
  always_ff @(posedge clk) begin
    if (reset || por) begin
      irq_en_q <= RST_IRQ_EN;
    end else if (ctrl_wr) begin
      irq_en_q <= io_wdata[BIT_READY_IRQ_EN];
    end
  end

  // mode field survives a plain reset while the array is busy
  always_ff @(posedge clk) begin
    if (por || (reset && !busy)) begin
      mode_q <= RST_MODE;
    end else if (ctrl_wr && !busy && !reset) begin
      mode_q <= io_wdata[BIT_MODE_HI:BIT_MODE_LO];
    end
  end

  // master write enable opens a four-cycle window
  always_ff @(posedge clk) begin
    if (reset || por) begin
      mwe_q     <= 1'b0;
      mwe_cnt_q <= 3'h0;
    end else if (ctrl_wr && io_wdata[BIT_MASTER_WE] && !io_wdata[BIT_WRITE_STROBE]) begin
      mwe_q     <= 1'b1;
      mwe_cnt_q <= MWE_WINDOW - 3'h1;
    end else if (start_wr) begin
      mwe_q     <= 1'b0;
      mwe_cnt_q <= 3'h0;
    end else if (mwe_q) begin
      mwe_cnt_q <= mwe_cnt_q - 3'h1;
      if (mwe_cnt_q == 3'h0) begin
        mwe_q <= 1'b0;
      end
    end
  end

  // read strobe lasts one cycle; the array answers in that cycle
  always_ff @(posedge clk) begin
    if (reset || por) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= read_req;
    end
  end

  // cpu halt after a strobe; a read stalls longer than a write
  always_ff @(posedge clk) begin
    if (reset || por) begin
      stall_q <= 3'h0;
    end else if (read_req) begin
      stall_q <= READ_STALL;
    end else if (start_wr) begin
      stall_q <= WRITE_STALL;
    end else if (stall_q != 3'h0) begin
      stall_q <= stall_q - 3'h1;
    end
  end

  // programming sequencer; a plain reset lets a running operation finish
  always_ff @(posedge clk) begin
    if (por) begin
      state_q    <= ST_IDLE;
      prog_cnt_q <= '0;
      op_addr_q  <= '0;
      op_data_q  <= RST_DATA;
    end else if (bod_q) begin
      state_q    <= ST_IDLE;
      prog_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_wr && !reset) begin
            op_addr_q <= addr_q;
            op_data_q <= data_q;
            case (mode_q)
              MODE_ERASE_WRITE: begin
                state_q    <= ST_ERASE;
                prog_cnt_q <= ERASE_LOAD;
              end
              MODE_ERASE_ONLY: begin
                state_q    <= ST_ERASE;
                prog_cnt_q <= ERASE_LOAD;
              end
              MODE_WRITE_ONLY: begin
                state_q    <= ST_WRITE;
                prog_cnt_q <= WRITE_LOAD;
              end
              default: begin
                state_q <= ST_IDLE;
              end
            endcase
          end
        end
        ST_ERASE: begin
          if (prog_cnt_q != '0) begin
            prog_cnt_q <= prog_cnt_q - PROG_CNT_W'(1);
          end else if (mode_q == MODE_ERASE_WRITE) begin
            state_q    <= ST_WRITE;
            prog_cnt_q <= WRITE_LOAD;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (prog_cnt_q != '0) begin
            prog_cnt_q <= prog_cnt_q - PROG_CNT_W'(1);
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // a brown-out abort is remembered until the next operation starts
  always_ff @(posedge clk) begin
    if (por) begin
      invalid_q <= 1'b0;
    end else if (bod_q && busy) begin
      invalid_q <= 1'b1;
    end else if (start_wr && !reset && (mode_q != MODE_RESERVED)) begin
      invalid_q <= 1'b0;
    end
  end

  // register read mux; unused and reserved bits read as zero
  always_comb begin
    io_rdata = 8'h00;
    case (io_addr)
      OFS_CONTROL: begin
        io_rdata[BIT_MODE_HI:BIT_MODE_LO] = mode_q;
        io_rdata[BIT_READY_IRQ_EN]        = irq_en_q;
        io_rdata[BIT_MASTER_WE]           = mwe_q;
        io_rdata[BIT_WRITE_STROBE]        = busy;
        io_rdata[BIT_READ_STROBE]         = rd_pend_q;
      end
      OFS_DATA:    io_rdata = data_q;
      OFS_ADDR_LO: io_rdata = addr_q[7:0];
      OFS_ADDR_HI: io_rdata = {6'h00, addr_q[ADDR_W-1:8]};
      default:     io_rdata = 8'h00;
    endcase
  end

  // array side: reads use the live address, programming the latched one
  assign arr_addr       = busy ? op_addr_q : addr_q;
  assign arr_wdata      = op_data_q;
  assign arr_read       = rd_pend_q;
  assign arr_erase      = (state_q == ST_ERASE);
  assign arr_write      = (state_q == ST_WRITE);
  assign result_invalid = invalid_q;
  assign cpu_stall      = (stall_q != 3'h0);
  assign ready_irq      = irq_en_q && global_irq_flag && !busy;

endmodule // eeprom_access_controller

/* tb/nv_array_model.sv */
// behavioural eeprom array standing behind the controller's array port
`timescale 1ns/10ps
module nv_array_model
  import nv_access_pkg::*;
(
  // clock
  input  wire logic              clk,
  // array port
  input  wire logic [ADDR_W-1:0] arr_addr,
  input  wire logic [7:0]        arr_wdata,
  input  wire logic              arr_read,
  input  wire logic              arr_erase,
  input  wire logic              arr_write,
  output logic      [7:0]        arr_rdata
);
  logic [7:0] mem [1024];
  logic [7:0] last_q = 8'h00;
  initial foreach (mem[i]) mem[i] = 8'hff;
  // off a read the bus shows the inverse of the last byte, so stale data cannot pass
  assign arr_rdata = arr_read ? mem[arr_addr] : ~last_q;
  always @(posedge clk) begin
    if (arr_read) last_q <= mem[arr_addr];
    if (arr_erase) mem[arr_addr] <= 8'hff;
    else if (arr_write) mem[arr_addr] <= mem[arr_addr] & arr_wdata;
  end
endmodule // nv_array_model

/* tb/nv_access_checker_sva.sv */
// port assertions for the eeprom access controller
`timescale 1ns/10ps
module nv_access_checker
  import nv_access_pkg::*;
#(
  parameter int ERASE_CYCLES = 8,
  parameter int WRITE_CYCLES = 8
) (
  // clock and resets
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       por,
  // cpu side
  input wire logic [5:0] io_addr,
  input wire logic       io_we,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       global_irq_flag,
  input wire logic       cpu_stall,
  input wire logic       ready_irq,
  // array side
  input wire logic       arr_read,
  input wire logic       arr_erase,
  input wire logic       arr_write,
  input wire logic [7:0] arr_rdata,
  input wire logic       result_invalid
);
  logic [2:0]  age_q;
  logic [15:0] len_q;
  wire busy = arr_erase | arr_write;
  wire ctl_wr = io_we && io_addr == OFS_CONTROL;
  default clocking @(posedge clk); endclocking
  default disable iff (reset || por);
  // enable age saturates at 7, safely past the four-cycle window
  always_ff @(posedge clk)
    if (reset || por) age_q <= 3'h7;
    else if (ctl_wr && io_wdata[2] && !io_wdata[1]) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  always_ff @(posedge clk) len_q <= arr_write ? len_q + 16'h1 : 16'h0;
  hi_addr_zero_a: assert property (io_addr == OFS_ADDR_HI |-> io_rdata[7:2] == 6'h00)
    else $error("address high bits not zero");
  ctl_rsvd_zero_a: assert property (io_addr == OFS_CONTROL |-> io_rdata[7:6] == 2'h0)
    else $error("control bits 7:6 not zero");
  read_start_a: assert property (ctl_wr && io_wdata[0] && !busy && !cpu_stall |=> arr_read)
    else $error("read strobe did not reach the array");
  read_stall_a: assert property ($rose(arr_read) |-> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  read_data_a: assert property (arr_read ##1 (io_addr == OFS_DATA) |->
    io_rdata == $past(arr_rdata)) else $error("data register missed fetched byte");
  busy_no_read_a: assert property (busy |-> !arr_read)
    else $error("array read while programming");
  irq_level_a: assert property (ready_irq |-> global_irq_flag && !busy)
    else $error("ready interrupt out of place");
  strobe_refused_a: assert property (ctl_wr && io_wdata[1] && age_q >= 3'h4 && !busy |=> !busy)
    else $error("strobe accepted without enable");
  write_len_a: assert property ($fell(arr_write) |-> result_invalid || len_q == 16'(WRITE_CYCLES))
    else $error("write phase length wrong");
  prog_stall_a: assert property ($rose(busy) |-> cpu_stall [*2] ##1 !cpu_stall)
    else $error("write stall not two cycles");
  cover property ($rose(arr_read));
  cover property ($fell(arr_write));
  cover property (ready_irq);
endmodule // nv_access_checker

/* tb/eeprom_access_controller_bench.sv */
// self-checking bench for the eeprom access controller
`timescale 1ns/10ps
module eeprom_access_controller_bench
  import nv_access_pkg::*;
;
  localparam int CYC = 8;
  logic clk = 1'b0, reset = 1'b1, por = 1'b1, brownout_detector = 1'b0;
  logic io_we = 1'b0, global_irq_flag = 1'b0, ie = 1'b0;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00, io_rdata, arr_wdata, arr_rdata, v;
  logic [9:0] arr_addr;
  logic cpu_stall, ready_irq, arr_read, arr_erase, arr_write, result_invalid;
  logic [31:0] lfsr_q = 32'hc37ea051;
  int err_total = 0, cmp_count = 0, cyc = 0, ref_mem [1024];
  eeprom_access_controller #(.ERASE_CYCLES(CYC), .WRITE_CYCLES(CYC)) i_eeprom_access_controller (
    .clk(clk), .reset(reset), .por(por), .brownout_detector(brownout_detector),
    .io_addr(io_addr), .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .global_irq_flag(global_irq_flag), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_read(arr_read), .arr_erase(arr_erase),
    .arr_write(arr_write), .arr_rdata(arr_rdata), .result_invalid(result_invalid));
  nv_array_model i_nv_array_model (.clk(clk), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_read(arr_read), .arr_erase(arr_erase), .arr_write(arr_write), .arr_rdata(arr_rdata));
  initial forever #2 clk = ~clk;
  task conclude;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  task chk(string n, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk);
    io_addr <= a; io_wdata <= d; io_we <= 1'b1;
    @(posedge clk);
    io_we <= 1'b0;
  endtask
  task rd(logic [5:0] a);
    @(posedge clk);
    io_addr <= a;
    #1 v = io_rdata;
  endtask
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task set_addr(int a);
    wr(OFS_ADDR_LO, a[7:0]);
    wr(OFS_ADDR_HI, a[15:8]);
  endtask
  // arm the enable, then strobe two cycles later, inside the window
  // no flash store-program runs here, and global interrupts stay off in the loop
  task prog(int a, logic [7:0] d, logic [1:0] m);
    set_addr(a);
    wr(OFS_DATA, d);
    wr(OFS_CONTROL, {2'b00, m, ie, 3'h4});
    wr(OFS_CONTROL, {2'b00, m, ie, 3'h2});
    if (m == MODE_ERASE_WRITE) ref_mem[a] = d;
    else if (m == MODE_ERASE_ONLY) ref_mem[a] = 255;
    else if (m == MODE_WRITE_ONLY) ref_mem[a] = ref_mem[a] & d;
  endtask
  task wait_idle;
    int n;
    n = 0;
    v = 8'h02;
    while (v[1] && n < 100) begin
      rd(OFS_CONTROL);
      n++;
    end
    chk("strobe cleared", {7'h00, v[1]}, 8'h00);
  endtask
  task readb(int a);
    set_addr(a);
    wr(OFS_CONTROL, {4'h0, ie, 3'h1});
    rd(OFS_DATA);
    chk("read byte", v, 8'(ref_mem[a]));
  endtask
  initial begin
    foreach (ref_mem[i]) ref_mem[i] = 255;
    repeat (6) @(posedge clk);
    reset <= 1'b0; por <= 1'b0;
    rd(OFS_DATA); chk("data reset", v, RST_DATA);
    rd(OFS_CONTROL); chk("control reset", v, 8'h00);
    wr(OFS_ADDR_HI, 8'hff); rd(OFS_ADDR_HI); chk("addr high", v, 8'h03);
    for (int i = 0; i < 8; i++) begin
      int a;
      lfsr_q = lfsr_next(lfsr_q);
      a = (i == 0) ? 0 : (i == 1) ? 1023 : int'(lfsr_q[9:0]);
      prog(a, lfsr_q[17:10], i[1:0]);
      wait_idle();
      readb(a);
    end
    wr(OFS_CONTROL, 8'h02); rd(OFS_CONTROL); chk("no arm", v, 8'h00);
    wr(OFS_CONTROL, 8'h04); rd(OFS_CONTROL); chk("armed", v, 8'h04);
    repeat (3) @(posedge clk);
    rd(OFS_CONTROL); chk("arm expired", v, 8'h00);
    wr(OFS_CONTROL, 8'h02); rd(OFS_CONTROL); chk("late strobe", v, 8'h00);
    prog(5, 8'h5a, MODE_ERASE_WRITE);
    wr(OFS_ADDR_LO, 8'h09); rd(OFS_ADDR_LO); chk("addr frozen", v, 8'h05);
    wr(OFS_CONTROL, 8'h21); rd(OFS_CONTROL); chk("busy control", v, 8'h02);
    wait_idle(); readb(5);
    prog(6, 8'h33, MODE_WRITE_ONLY);
    reset <= 1'b1; @(posedge clk); reset <= 1'b0;
    rd(OFS_CONTROL); chk("mode kept", v, 8'h22);
    wait_idle();
    reset <= 1'b1; @(posedge clk); reset <= 1'b0;
    rd(OFS_CONTROL); chk("mode cleared", v, 8'h00);
    readb(6);
    ie = 1'b1;
    wr(OFS_CONTROL, 8'h08); #1 chk("irq masked", {7'h00, ready_irq}, 8'h00);
    global_irq_flag <= 1'b1; @(posedge clk); #1 chk("irq on", {7'h00, ready_irq}, 8'h01);
    prog(7, 8'h11, MODE_WRITE_ONLY); #1 chk("irq busy", {7'h00, ready_irq}, 8'h00);
    wait_idle(); chk("irq level", {7'h00, ready_irq}, 8'h01);
    prog(8, 8'h77, MODE_ERASE_WRITE);
    brownout_detector <= 1'b1; repeat (4) @(posedge clk); brownout_detector <= 1'b0;
    #1 chk("result invalid", {7'h00, result_invalid}, 8'h01);
    conclude();
  end
endmodule // eeprom_access_controller_bench
bind eeprom_access_controller nv_access_checker #(.ERASE_CYCLES(ERASE_CYCLES),
  .WRITE_CYCLES(WRITE_CYCLES)) i_nv_access_checker (.clk(clk), .reset(reset), .por(por),
  .io_addr(io_addr), .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .global_irq_flag(global_irq_flag), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
  .arr_read(arr_read), .arr_erase(arr_erase), .arr_write(arr_write), .arr_rdata(arr_rdata),
  .result_invalid(result_invalid));
